// [hdl/css_clock_select.sv]
// clock source select, start-up timing and clock domain gating
// Behaviour
// RULE1 - cpu clock gate off whenever the core must not execute
// RULE2 - wake events seen by always-running logic while the i/o clock is gated
// RULE3 - async timer clock keeps running in sleep when fed externally
// RULE4 - converter clock stays on while cpu and i/o clocks are gated; here on only in noise mode, gated in power-down
// RULE5 - codes 0000, 0010, 0011, 01xx select external, rc, watchdog, low-frequency crystal
// RULE6 - codes 1xxx select crystal ranges; low bit picks the start-up option
// RULE7 - pin a is clock input or oscillator; pin b oscillator or clock output
// RULE8 - fuse bits read one unprogrammed and zero programmed
// RULE9 - count source start-up cycles after wake or source switch before running; here counted after power-down wake or switch; noise-mode wake runs at once
// RULE10 - after reset wait 512 or 8192 watchdog cycles
// RULE11 - reset copies fuses into runtime clock select register, then uses it
// RULE12 - defaults are rc source, start-up 10, divide by eight on
// RULE13 - reset loads factory calibration into the rc calibration register
// RULE14 - software may rewrite the calibration register; value is applied
// RULE15 - watchdog oscillator clock stays enabled in every source mode
// RULE16 - rc start-up: 6 clocks from sleep, 14 plus none/short/long from reset
// RULE17 - rc start-up 00 only while reset pin disable fuse is unset
// RULE18 - software avoids code 0001 and start-up 11
//
// Local design decisions: the APB register port and the address map.
`timescale 1ns/1ps
`default_nettype none
module css_clock_select
	import css_pkg::*;
#(
	parameter logic [15:0] WDT_LONG = 16'h2000,
	parameter logic [15:0] XT_SLOW  = 16'h4000
)(
	input  wire logic        SYS_CLK,
	input  wire logic        RST,
	input  wire logic        CE,
	input  wire logic [11:0] PADDR,
	input  wire logic        PSEL,
	input  wire logic        PENABLE,
	input  wire logic        PWRITE,
	input  wire logic [31:0] PWDATA,
	output logic      [31:0] PRDATA,
	output logic             PREADY,
	output logic             PSLVERR,
	input  wire logic [3:0]  SRC_FUSES,
	input  wire logic [1:0]  STUP_FUSES,
	input  wire logic        DIV8_FUSE,
	input  wire logic        RSTDIS_FUSE,
	input  wire logic [7:0]  FACTORY_CAL,
	input  wire logic        WDT_TICK,
	input  wire logic        SRC_TICK,
	input  wire logic        WAKE,
	output logic             CPU_CLK_EN,
	output logic             IO_CLK_EN,
	output logic             FLASH_CLK_EN,
	output logic             ASY_CLK_EN,
	output logic             ADC_CLK_EN,
	output logic             WDT_CLK_EN,
	output logic             WAKE_SEEN,
	output logic [3:0]       SRC_SEL,
	output logic [7:0]       RC_CAL,
	output logic             DIV8_EN,
	output logic [1:0]       PIN_A_FUNC,
	output logic [1:0]       PIN_B_FUNC,
	output logic             CLK_OUT_EN
);
	// ****************************************
	// pin synchronisers
	// ****************************************
	logic [NSYNC-1:0] pin_in;
	logic [NSYNC-1:0] pin_rise;
	assign pin_in = {WAKE, SRC_TICK, WDT_TICK};
	genvar gi;
	generate
		for (gi = 0; gi < NSYNC; gi++)
		begin : g_sync
			logic s1_reg;
			logic s2_reg;
			logic s3_reg;
			logic flt_reg;
			always_ff @(posedge SYS_CLK)
			begin
				if (RST)
				begin
					s1_reg  <= 1'b0;
					s2_reg  <= 1'b0;
					s3_reg  <= 1'b0;
					flt_reg <= 1'b0;
				end
				else if (CE)
				begin
					s1_reg <= pin_in[gi];
					s2_reg <= s1_reg;
					s3_reg <= s2_reg;
					if (s2_reg == s3_reg)
						flt_reg <= s3_reg;
				end
			end
			assign pin_rise[gi] = (s2_reg == s3_reg) && s3_reg && !flt_reg;
		end
	endgenerate
	logic wdt_rise;
	logic src_rise;
	logic wake_rise;
	assign wdt_rise  = pin_rise[0];
	assign src_rise  = pin_rise[1];
	assign wake_rise = pin_rise[2];

	// ****************************************
	// state and registers
	// ****************************************
	css_state_t  state_reg;
	css_state_t  state_next;
	logic [15:0] cnt_reg;
	logic [15:0] cnt_next;
	logic [5:0]  csr_reg;
	logic [5:0]  csr_next;
	logic [7:0]  cal_reg;
	logic [7:0]  cal_next;
	logic        div8_reg;
	logic        div8_next;
	logic        ckout_reg;
	logic        ckout_next;
	logic        rdy_reg;

	// ****************************************
	// source decode
	// ****************************************
	logic [3:0] src;
	logic [1:0] stup;
	logic       is_ext;
	logic       is_lf;
	logic       is_xt;
	logic       is_osc;
	assign src    = csr_reg[3:0];
	assign stup   = csr_reg[CSR_STUP_LSB+1:CSR_STUP_LSB];
	assign is_ext = (src == SRC_EXT);                    // [RULE5]
	assign is_lf  = (src[3:2] == 2'b01);                 // [RULE5]
	assign is_xt  = src[3];                              // [RULE6]
	assign is_osc = is_lf || is_xt;

	// sleep start-up in cycles of the selected source
	function automatic logic [15:0] pd_ck(input logic [3:0] s, input logic [1:0] t);
		logic [15:0] r;
		r = RC_PD_CK;                                    // [RULE16]
		if (s[3])
		begin
			if (!s[0] && !t[1])                          // [RULE6]
				r = XT_FAST;
			else if (!s[0] || t == STUP_BOD)
				r = XT_MID;
			else
				r = XT_SLOW;
		end
		else if (s[3:2] == 2'b01)
			r = LF_CK;
		return r;
	endfunction

	// extra reset delay in watchdog cycles; reserved code 11 falls to the long wait, but to the short wait on low-frequency and even crystal codes
	function automatic logic [15:0] rst_dly(input logic [3:0] s, input logic [1:0] t);
		logic [15:0] r;
		logic [2:0]  k;
		k = {s[0], t};
		r = WDT_LONG;
		if (s[3])
		begin
			if (k == 3'h2 || k == 3'h5)
				r = NO_DLY;
			else if (k == 3'h0 || k == 3'h3 || k == 3'h6)
				r = WDT_SHORT;
		end
		else if (s[3:2] == 2'b01)
			r = WDT_SHORT;
		else if (t == STUP_BOD)                          // [RULE16]
			r = NO_DLY;
		else if (t == STUP_FAST)                         // [RULE10]
			r = WDT_SHORT;
		return r;                                        // [RULE18]
	endfunction

	// ****************************************
	// apb decode
	// ****************************************
	logic        hit_csr;
	logic        hit_cal;
	logic        hit_ctl;
	logic        hit_stat;
	logic        hit_any;
	logic        acc;
	logic        wr;
	logic [31:0] rd_mux;
	assign hit_csr  = (PADDR == OFS_CSR);
	assign hit_cal  = (PADDR == OFS_CAL);
	assign hit_ctl  = (PADDR == OFS_CTL);
	assign hit_stat = (PADDR == OFS_STAT);
	assign hit_any  = hit_csr || hit_cal || hit_ctl || hit_stat;
	assign acc      = PSEL && PENABLE && !rdy_reg;
	assign wr       = PSEL && PENABLE && PWRITE && rdy_reg;
	assign rd_mux   = hit_csr  ? {26'h0, csr_reg} :
		hit_cal  ? {24'h0, cal_reg} :
		hit_ctl  ? {29'h0, ckout_reg, 2'b00} :
		hit_stat ? {24'h0, RSTDIS_FUSE, div8_reg, 3'b000, state_reg} : 32'h0;

	// the switch request is ignored unless the core runs, so a start-up never restarts
	logic sw_req;
	logic pd_req;
	logic nz_req;
	logic rc_bod_locked;
	assign sw_req = wr && hit_csr && state_reg == ST_RUN;
	assign pd_req = wr && hit_ctl && PWDATA[CTL_PDOWN];
	assign nz_req = wr && hit_ctl && PWDATA[CTL_NOISE];
	assign rc_bod_locked = (SRC_FUSES == SRC_RC) && (STUP_FUSES == STUP_BOD)
		&& (RSTDIS_FUSE == FUSE_PROG);                   // [RULE17]

	// ****************************************
	// sequencer
	// ****************************************
	always_comb
	begin
		state_next = state_reg;
		cnt_next   = cnt_reg;
		csr_next   = csr_reg;
		cal_next   = cal_reg;
		div8_next  = div8_reg;
		ckout_next = ckout_reg;
		if (wr && hit_cal)
			cal_next = PWDATA[7:0];                      // [RULE14]
		if (wr && hit_ctl)
			ckout_next = PWDATA[CTL_CKOUT];
		case (state_reg)
			ST_LOAD:
			begin
				csr_next   = {rc_bod_locked ? STUP_FAST : STUP_FUSES, SRC_FUSES}; // [RULE11] [RULE17]
				cal_next   = FACTORY_CAL;                // [RULE13]
				div8_next  = (DIV8_FUSE == FUSE_PROG);   // [RULE8]
				cnt_next   = 16'h0;
				state_next = ST_RDLY;
			end
			ST_RDLY:
			begin
				if (cnt_reg >= rst_dly(src, stup))       // [RULE10] [RULE15]
				begin
					cnt_next   = 16'h0;
					state_next = ST_RCK;
				end
				else if (wdt_rise)
					cnt_next = cnt_reg + 16'h1;
			end
			ST_RCK:
			begin
				if (cnt_reg >= RST_CK)                   // [RULE16]
					state_next = ST_RUN;
				else if (src_rise)
					cnt_next = cnt_reg + 16'h1;
			end
			ST_RUN:
			begin
				cnt_next = 16'h0;
				if (sw_req)
				begin
					csr_next   = PWDATA[5:0];
					state_next = ST_START;
				end
				else if (pd_req)
					state_next = ST_PDN;
				else if (nz_req)
					state_next = ST_NOISE;
			end
			ST_PDN:
			begin
				if (wake_rise)                           // [RULE2]
					state_next = ST_START;
			end
			ST_NOISE:
			begin
				if (wake_rise)                           // [RULE2]
					state_next = ST_RUN;
			end
			default:
			begin
				if (cnt_reg >= pd_ck(src, stup))         // [RULE9]
					state_next = ST_RUN;
				else if (src_rise)
					cnt_next = cnt_reg + 16'h1;
			end
		endcase
	end

	// ****************************************
	// output next values
	// ****************************************
	logic       run;
	logic       asy_src;
	logic [1:0] pa_next;
	logic [1:0] pb_next;
	logic       cko_next;
	assign run      = (state_next == ST_RUN);
	assign asy_src  = is_ext || is_lf;
	assign cko_next = ckout_reg && !is_osc;
	assign pa_next  = is_ext ? PIN_CLKIN : (is_osc ? PIN_OSC : PIN_GPIO);   // [RULE7]
	assign pb_next  = is_osc ? PIN_OSC : (cko_next ? PIN_CLKOUT : PIN_GPIO); // [RULE7]

	always_ff @(posedge SYS_CLK)
	begin
		if (RST)
		begin
			state_reg <= ST_LOAD;
			cnt_reg   <= 16'h0;
			csr_reg   <= {STUP_DEF, SRC_DEF};            // [RULE12]
			cal_reg   <= CAL_RST;
			div8_reg  <= 1'b1;                           // [RULE12]
			ckout_reg <= 1'b0;
		end
		else if (CE)
		begin
			state_reg <= state_next;
			cnt_reg   <= cnt_next;
			csr_reg   <= csr_next;
			cal_reg   <= cal_next;
			div8_reg  <= div8_next;
			ckout_reg <= ckout_next;
		end
	end

	// registered outputs; the clock gates take the next state and lag the sequencer by no cycle, the other outputs lag their registers by one
	always_ff @(posedge SYS_CLK)
	begin
		if (RST)
		begin
			CPU_CLK_EN   <= 1'b0;
			IO_CLK_EN    <= 1'b0;
			FLASH_CLK_EN <= 1'b0;
			ASY_CLK_EN   <= 1'b0;
			ADC_CLK_EN   <= 1'b0;
			WDT_CLK_EN   <= 1'b1;
			WAKE_SEEN    <= 1'b0;
			SRC_SEL      <= SRC_DEF;
			RC_CAL       <= CAL_RST;
			DIV8_EN      <= 1'b1;
			PIN_A_FUNC   <= PIN_GPIO;
			PIN_B_FUNC   <= PIN_GPIO;
			CLK_OUT_EN   <= 1'b0;
		end
		else if (CE)
		begin
			CPU_CLK_EN   <= run;                                    // [RULE1]
			IO_CLK_EN    <= run;
			FLASH_CLK_EN <= run;
			ASY_CLK_EN   <= run || asy_src;                         // [RULE3]
			ADC_CLK_EN   <= run || state_next == ST_NOISE;          // [RULE4]
			WDT_CLK_EN   <= 1'b1;                                   // [RULE15]
			WAKE_SEEN    <= wake_rise;                              // [RULE2]
			SRC_SEL      <= src;
			RC_CAL       <= cal_reg;                                // [RULE14]
			DIV8_EN      <= div8_reg;
			PIN_A_FUNC   <= pa_next;
			PIN_B_FUNC   <= pb_next;
			CLK_OUT_EN   <= cko_next;
		end
	end

	// ****************************************
	// apb slave: one wait state, then answer
	// ****************************************
	always_ff @(posedge SYS_CLK)
	begin
		if (RST)
		begin
			rdy_reg <= 1'b0;
			PREADY  <= 1'b0;
			PRDATA  <= 32'h0;
			PSLVERR <= 1'b0;
		end
		else if (CE)
		begin
			rdy_reg <= acc;
			PREADY  <= acc;
			PSLVERR <= acc && !hit_any;
			PRDATA  <= (acc && !PWRITE) ? rd_mux : 32'h0;
		end
	end

	// ****************************************
	// checks
	// ****************************************
	default clocking cb @(posedge SYS_CLK); endclocking
	default disable iff (RST);

	load_copy_a: assert property (state_reg == ST_LOAD && CE |=> csr_reg[3:0] == $past(SRC_FUSES)) // [RULE11]
		else $error("source fuses not copied at reset");
	cal_load_a: assert property (state_reg == ST_LOAD && CE |=> cal_reg == $past(FACTORY_CAL)) // [RULE13]
		else $error("calibration not loaded at reset");
	cpu_freeze_a: assert property (CE && state_next != ST_RUN |=> !CPU_CLK_EN && !IO_CLK_EN) // [RULE1]
		else $error("cpu clock running outside run state");
	wdt_on_a: assert property (WDT_CLK_EN) // [RULE15]
		else $error("watchdog clock dropped");
	adc_noise_a: assert property (state_reg == ST_NOISE && CE && !wake_rise |=> ADC_CLK_EN && !CPU_CLK_EN) // [RULE4]
		else $error("converter clock gated in noise mode");
	asy_sleep_a: assert property (state_reg == ST_PDN && CE && asy_src && !wake_rise |=> ASY_CLK_EN) // [RULE3]
		else $error("async timer clock stopped in sleep");
	pin_ext_a: assert property (CE && is_ext && state_reg != ST_LOAD && !sw_req |=> PIN_A_FUNC == PIN_CLKIN) // [RULE7]
		else $error("pin a not clock input with external clock");
	bod_lock_a: assert property (state_reg == ST_LOAD && CE && rc_bod_locked // [RULE17]
		|=> stup == STUP_FAST)
		else $error("start-up 00 kept with reset pin disabled");
	rc_wake_a: assert property (state_reg == ST_START && src == SRC_RC && cnt_reg < RC_PD_CK |-> ##1 state_reg != ST_RUN) // [RULE16]
		else $error("rc wake before six clocks");
	short_dly_a: assert property (state_reg == ST_RDLY && !is_xt && !is_lf // [RULE10]
		&& stup == STUP_FAST && cnt_reg < WDT_SHORT |=> state_reg == ST_RDLY)
		else $error("reset delay ended early");
	wake_c: cover property (state_reg == ST_PDN ##1 state_reg == ST_START);
	switch_c: cover property (sw_req);
	noise_c: cover property (state_reg == ST_NOISE ##1 state_reg == ST_RUN);
endmodule
`default_nettype wire

// [hdl/css_pkg.sv]
// constants and types for the clock source select and start-up block
`default_nettype none
package css_pkg;
	// ****************************************
	// source codes and factory defaults
	// ****************************************
	localparam logic [3:0] SRC_EXT   = 4'h0;
	localparam logic [3:0] SRC_RC    = 4'h2;
	localparam logic [3:0] SRC_WDT   = 4'h3;
	localparam logic [3:0] SRC_DEF   = 4'h2;
	localparam logic [1:0] STUP_DEF  = 2'h2;
	localparam logic [1:0] STUP_BOD  = 2'h0;
	localparam logic [1:0] STUP_FAST = 2'h1;
	localparam logic       FUSE_PROG = 1'b0;
	localparam logic [7:0] CAL_RST   = 8'h00;
	// ****************************************
	// register map, byte addresses
	// ****************************************
	localparam logic [11:0] OFS_CSR  = 12'h000;
	localparam logic [11:0] OFS_CAL  = 12'h004;
	localparam logic [11:0] OFS_CTL  = 12'h008;
	localparam logic [11:0] OFS_STAT = 12'h00c;
	localparam int CSR_STUP_LSB = 4;
	localparam int CTL_PDOWN   = 0;
	localparam int CTL_NOISE   = 1;
	localparam int CTL_CKOUT   = 2;
	// ****************************************
	// start-up counts in oscillator cycles
	// ****************************************
	localparam logic [15:0] RC_PD_CK  = 16'h0006;
	localparam logic [15:0] RST_CK    = 16'h000e;
	localparam logic [15:0] WDT_SHORT = 16'h0200;
	localparam logic [15:0] XT_FAST   = 16'h0102;
	localparam logic [15:0] XT_MID    = 16'h0400;
	localparam logic [15:0] LF_CK     = 16'h0400;
	localparam logic [15:0] NO_DLY    = 16'h0000;
	// ****************************************
	// shared pin functions
	// ****************************************
	localparam logic [1:0] PIN_GPIO   = 2'h0;
	localparam logic [1:0] PIN_CLKIN  = 2'h1;
	localparam logic [1:0] PIN_CLKOUT = 2'h1;
	localparam logic [1:0] PIN_OSC    = 2'h2;
	localparam int NSYNC = 3;
	typedef enum logic [2:0] {ST_LOAD, ST_RDLY, ST_RCK, ST_RUN, ST_PDN, ST_NOISE, ST_START}
		css_state_t;
endpackage
`default_nettype wire

// [testbench/css_osc_model.sv]
// free-running oscillator model for the watchdog and the selected clock source
`timescale 1ns/1ps
`default_nettype none
module css_osc_model #(
	parameter int HALF = 2
)(
	input  wire logic clk,
	input  wire logic run,
	output logic      tick
);
	int   cnt = 0;
	logic lvl = 1'b0;
	// ****************************************
	// level toggles every HALF system clocks
	// ****************************************
	// a real source never stops once powered; run low models a dead oscillator
	assign tick = lvl;
	always @(posedge clk)
	begin
		if (run)
		begin
			if (cnt == HALF - 1)
			begin
				cnt <= 0;
				lvl <= ~lvl;
			end
			else
				cnt <= cnt + 1;
		end
	end
endmodule
`default_nettype wire

// [testbench/tb_top.sv]
// self-checking bench for the clock source select and start-up block
`timescale 1ns/1ps
`default_nettype none
module tb_top import css_pkg::*;;
	localparam int WP = 6;
	localparam int SP = 4;
	localparam int WLONG = 16;
	localparam int XSLOW = 32;
	localparam int SRCS[7] = '{0, 3, 5, 9, 12, 15, 2};
	localparam int SUTS[4] = '{0, 1, 2, 0};
	logic        sys_clk = 1'b0;
	logic        rst = 1'b1;
	logic [11:0] paddr = 12'h000;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [31:0] pwdata = 32'h0;
	logic [3:0]  fuse_src = SRC_DEF;
	logic [1:0]  fuse_stup = STUP_DEF;
	logic        div8 = FUSE_PROG;
	logic        rstdis = 1'b1;
	logic [7:0]  cal = 8'h00;
	logic        wake = 1'b0;
	logic        ce = 1'b1;
	logic        src_run = 1'b1;
	logic [31:0] prdata;
	logic [3:0]  src_sel;
	logic [7:0]  rc_cal;
	logic [1:0]  pin_a, pin_b;
	logic        pready, pslverr, wdt_tick, src_tick, cpu_en, io_en, fl_en, asy_en, adc_en;
	logic        wdt_en, wake_seen, div8_en, clk_out_en;
	int          err_count = 0;
	int          tests_run = 0;

	always #50 sys_clk = ~sys_clk;

	css_osc_model #(.HALF(3)) wdt_osc_u (.clk(sys_clk), .run(1'b1), .tick(wdt_tick));
	css_osc_model #(.HALF(2)) src_osc_u (.clk(sys_clk), .run(src_run), .tick(src_tick));

	css_clock_select #(.WDT_LONG(16'(WLONG)), .XT_SLOW(16'(XSLOW))) dut_u (
		.SYS_CLK(sys_clk), .RST(rst), .CE(ce), .PADDR(paddr), .PSEL(psel),
		.PENABLE(penable), .PWRITE(pwrite), .PWDATA(pwdata), .PRDATA(prdata),
		.PREADY(pready), .PSLVERR(pslverr), .SRC_FUSES(fuse_src), .STUP_FUSES(fuse_stup),
		.DIV8_FUSE(div8), .RSTDIS_FUSE(rstdis), .FACTORY_CAL(cal), .WDT_TICK(wdt_tick),
		.SRC_TICK(src_tick), .WAKE(wake), .CPU_CLK_EN(cpu_en), .IO_CLK_EN(io_en),
		.FLASH_CLK_EN(fl_en), .ASY_CLK_EN(asy_en), .ADC_CLK_EN(adc_en), .WDT_CLK_EN(wdt_en),
		.WAKE_SEEN(wake_seen), .SRC_SEL(src_sel), .RC_CAL(rc_cal), .DIV8_EN(div8_en),
		.PIN_A_FUNC(pin_a), .PIN_B_FUNC(pin_b), .CLK_OUT_EN(clk_out_en));

	// ****************************************
	// reference model and checking
	// ****************************************
	function automatic logic xtal(input logic [3:0] s);
		return s[3] || s[3:2] == 2'b01;
	endfunction

	// rc source: reset delay in watchdog ticks, then 14 source ticks
	function automatic int rst_cyc(input int stup, input bit rdis_set);
		int w;
		w = (stup == 2) ? WLONG : ((stup == 1 || rdis_set) ? 512 : 0);
		return w * WP + 14 * SP;
	endfunction

	// power-down wake: source ticks counted before the core runs
	function automatic int wake_ticks(input logic [3:0] s, input logic [1:0] t);
		if (s[3:2] == 2'b01)
			return 1024;
		if (!s[3])
			return 6;
		if (!s[0])
			return t[1] ? 1024 : 258;
		return (t == 2'h0) ? 1024 : XSLOW;
	endfunction

	task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string m);
		tests_run++;
		if (seen !== exp)
		begin
			err_count++;
			$display("mismatch at %0t: %s seen %h expected %h", $time, m, seen, exp);
		end
	endtask

	task automatic in_win(input int n, input int lo, input int hi, input string m);
		check(32'(n >= lo && n <= hi), 32'h1, m);
	endtask

	task automatic end_sim();
		$display("comparisons %0d mismatches %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	// ****************************************
	// bus and sequence tasks
	// ****************************************
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] r, output logic e);
		int n;
		psel <= 1'b1;
		paddr <= a;
		pwrite <= w;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1'b1;
		n = 0;
		do
		begin
			@(posedge sys_clk);
			n++;
		end
		while (pready !== 1'b1 && n < 50);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		check(32'(pready), 32'h1, "bus answer");
		@(posedge sys_clk);
	endtask

	task automatic apb_wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic        e;
		apb(1'b1, a, d, r, e);
	endtask

	task automatic apb_rd(input logic [11:0] a, input logic [31:0] x, input string m);
		logic [31:0] r;
		logic        e;
		apb(1'b0, a, 32'h0, r, e);
		check(r, x, m);
	endtask

	task automatic wait_cpu(input logic lvl, input int lim, output int n);
		n = 0;
		while (cpu_en !== lvl && n < lim)
		begin
			@(posedge sys_clk);
			n++;
		end
		check(32'(cpu_en), 32'(lvl), "cpu clock level");
	endtask

	task automatic do_reset(input logic [3:0] s, input logic [1:0] t, input logic rd,
		input logic d8, output int n);
		fuse_src <= s;
		fuse_stup <= t;
		rstdis <= rd;
		div8 <= d8;
		cal <= 8'($urandom);
		rst <= 1'b1;
		repeat (10) @(posedge sys_clk);
		check(32'({cpu_en, wdt_en}), 32'h1, "reset gates");
		rst <= 1'b0;
		wait_cpu(1'b1, 12000, n);
		check(32'(div8_en), {31'h0, ~d8}, "divide flag");
		check(32'(rc_cal), 32'(cal), "factory cal");
	endtask

	task automatic wake_up(output int n);
		int k;
		wake <= 1'b1;
		k = 0;
		while (wake_seen !== 1'b1 && k < 20)
		begin
			@(posedge sys_clk);
			k++;
		end
		check(32'(wake_seen), 32'h1, "wake seen");
		wake <= 1'b0;
		wait_cpu(1'b1, 20000, n);
	endtask

	// ****************************************
	// main sequence
	// ****************************************
	initial
	begin
		int          n;
		int          k;
		logic [3:0]  s;
		logic [7:0]  v;
		logic [31:0] r;
		logic        e;
		void'($urandom(32'hbfc1));
		// codes 0001 and start-up 11 are never applied
		for (int i = 0; i < 4; i++)
		begin
			do_reset(SRC_RC, 2'(SUTS[i]), i != 3, 1'($urandom), n);
			in_win(n, rst_cyc(SUTS[i], i == 3) - 10, rst_cyc(SUTS[i], i == 3) + 26, "reset time");
			$display("test reset delay %0d done", i);
		end
		for (int i = 0; i < 7; i++)
		begin
			s = 4'(SRCS[i]);
			do_reset(s, STUP_FAST, 1'b1, 1'($urandom), n);
			check(32'(src_sel), 32'(s), "source copy");
			check(32'(pin_a), 32'(s == SRC_EXT ? PIN_CLKIN : (xtal(s) ? PIN_OSC : PIN_GPIO)), "pin a");
			check(32'(pin_b), 32'(xtal(s) ? PIN_OSC : PIN_GPIO), "pin b");
			apb_rd(OFS_CSR, {26'h0, STUP_FAST, s}, "csr read");
			apb_wr(OFS_CTL, 32'h1);
			repeat (3) @(posedge sys_clk);
			check(32'({cpu_en, io_en, fl_en, adc_en, wdt_en, asy_en}), 32'({5'b00001, s == SRC_EXT || s[3:2] == 2'b01}), "sleep gates");
			wake_up(n);
			k = wake_ticks(s, STUP_FAST) * SP;
			in_win(n, k - 6, k + 12, "wake time");
			$display("test source %h done", s);
		end
		do_reset(SRC_DEF, STUP_DEF, 1'b1, FUSE_PROG, n);
		check(32'({src_sel, div8_en}), 32'({SRC_RC, 1'b1}), "defaults");
		apb_rd(OFS_CAL, {24'h0, cal}, "cal read");
		v = 8'($urandom);
		apb_wr(OFS_CAL, {24'h0, v});
		apb_rd(OFS_CAL, {24'h0, v}, "cal write");
		check(32'(rc_cal), 32'(v), "cal applied");
		apb_rd(OFS_STAT, 32'h000000c3, "status");
		apb(1'b0, 12'h010, 32'h0, r, e);
		check({31'h0, e}, 32'h1, "unmapped error");
		check(r, 32'h0, "unmapped data");
		apb_wr(OFS_CTL, 32'h4);
		repeat (2) @(posedge sys_clk);
		check(32'({clk_out_en, pin_b}), 32'({1'b1, PIN_CLKOUT}), "clock out");
		apb_wr(OFS_CTL, 32'h2);
		repeat (3) @(posedge sys_clk);
		check(32'({cpu_en, io_en, fl_en, adc_en}), 32'h1, "noise gates");
		// a wake edge while the enable is low must be lost: all state frozen
		ce <= 1'b0;
		wake <= 1'b1;
		repeat (8) @(posedge sys_clk);
		wake <= 1'b0;
		repeat (4) @(posedge sys_clk);
		ce <= 1'b1;
		repeat (8) @(posedge sys_clk);
		check(32'({cpu_en, adc_en, wake_seen}), 32'h2, "wake lost while disabled");
		wake_up(n);
		in_win(n, 0, 4, "noise wake");
		$display("test registers done");
		// a dead new source must hold the core off until it ticks
		src_run <= 1'b0;
		apb_wr(OFS_CSR, 32'h13);
		wait_cpu(1'b0, 10, n);
		repeat (100) @(posedge sys_clk);
		check(32'(cpu_en), 32'h0, "dead source holds");
		src_run <= 1'b1;
		wait_cpu(1'b1, 2000, n);
		check(32'({src_sel, pin_a}), 32'({SRC_WDT, PIN_GPIO}), "switched source");
		$display("test source switch done");
		end_sim();
	end

	initial
	begin
		#(100 * 90000);
		err_count++;
		end_sim();
	end
endmodule
`default_nettype wire
